// *** include/t2c_pkg.sv ***
// constants and types shared by the timer two control block
package t2c_pkg;

    // control register location and reset value
    localparam logic [7:0] T2C_CTRL_ADDR = 8'hC8;
    localparam logic [7:0] T2C_CTRL_PAGE = 8'h00;
    localparam logic [7:0] T2C_CTRL_RESET = 8'h00;
    localparam logic [4:0] T2C_BIT_BASE = 5'h19;

    // bit positions inside the control register
    localparam int unsigned T2C_POS_HI_FLAG = 7;
    localparam int unsigned T2C_POS_LO_FLAG = 6;
    localparam int unsigned T2C_POS_LO_IRQ_EN = 5;
    localparam int unsigned T2C_POS_CAP_EN = 4;
    localparam int unsigned T2C_POS_SPLIT = 3;
    localparam int unsigned T2C_POS_RUN = 2;
    localparam int unsigned T2C_POS_UNUSED = 1;
    localparam int unsigned T2C_POS_EXT_SEL = 0;

    // system clock divided by twelve
    localparam logic [3:0] T2C_DIV12_LAST = 4'hB;
    localparam logic [3:0] T2C_DIV12_RESET = 4'h0;
    localparam logic [7:0] T2C_BYTE_RESET = 8'h00;

    typedef struct packed {
        logic high_overflow_flag;
        logic low_overflow_flag;
        logic low_byte_irq_enable;
        logic capture_mode_enable;
        logic split_mode_select;
        logic run_control;
        logic unused;
        logic external_clock_select;
    } t2c_ctrl_type;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } t2c_count_type;

endpackage : t2c_pkg

// *** rtl/t2c_ext_sync.sv ***
// synchroniser and falling edge detector for the external clock divided by eight
module t2c_ext_sync
    import t2c_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic ext_i,
    output logic fall_o
);

    logic meta_q;
    logic sync_q;
    logic last_q;

    // two flops before any logic looks at the pin
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= ext_i;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign fall_o = last_q & ~sync_q;

endmodule : t2c_ext_sync

// *** rtl/t2c_count_byte.sv ***
// one auto-reload count byte with increment and load
module t2c_count_byte
    import t2c_pkg::*;
#(
    parameter int unsigned W = 8
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic inc_i,
    input wire logic load_i,
    input wire logic [W-1:0] load_val_i,
    output logic [W-1:0] count_o,
    output logic wrap_o
);

    logic [W-1:0] count_q;

    // load has priority, otherwise step by one when enabled
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            count_q <= '0;
        end else if (load_i) begin
            count_q <= load_val_i;
        end else if (inc_i) begin
            count_q <= count_q + {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign count_o = count_q;
    assign wrap_o = inc_i & (count_q == {W{1'b1}});

endmodule : t2c_count_byte

// *** rtl/t2c_timer_ctrl.sv ***
// control, clocking and capture logic of the timer two block
// Functional notes
// - high byte wrap sets high overflow flag
// - 16-bit wrap sets high overflow flag
// - enabled high flag requests timer interrupt
// - overflow flags cleared only by software
// - low byte wrap sets low flag
// - low irq enable adds low interrupts
// - capture enable bit switches capture mode
// - capture copies count, sets high flag
// - capture on synced external falling edge
// - split bit selects 16 or 2x8
// - 16-bit wrap loads reload value
// - run gates counter, split gates high only
// - control bit one reads zero
// - external select picks div12 or ext/8
// - split external select applies both bytes
// - per-byte system_clock select overrides source
// - control at 0xC8 page 0, bit-addressable
module t2c_timer_ctrl
    import t2c_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_page_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_bit_wr_i,
    input wire logic sfr_bit_val_i,
    input wire logic timer_irq_enable_i,
    input wire logic high_byte_system_clock_select_i,
    input wire logic low_byte_system_clock_select_i,
    input wire t2c_count_type reload_i,
    input wire logic ext_clk_div8_i,
    output logic [7:0] sfr_rdata_o,
    output logic sfr_rvalid_o,
    output logic irq_o,
    output t2c_count_type count_o,
    output logic capture_valid_o,
    output t2c_count_type capture_value_o
);

    t2c_ctrl_type ctrl_q;
    t2c_ctrl_type ctrl_d;
    logic [3:0] div_q;
    logic div12_tick;
    logic ext_tick;
    logic lo_tick;
    logic hi_tick;
    logic byte_hit;
    logic bit_hit;
    logic [2:0] bit_idx;
    logic [7:0] wr_mask;
    logic [7:0] wr_val;
    logic lo_inc;
    logic lo_load;
    logic hi_inc;
    logic hi_load;
    logic lo_wrap;
    logic hi_wrap;
    logic full_wrap;
    logic cap_evt;
    logic hi_set;
    logic lo_set;
    logic [7:0] rdata_q;
    logic rvalid_q;
    logic cap_valid_q;
    t2c_count_type cap_value_q;
    t2c_count_type count;

    // register decode, byte and bit access on page zero
    assign byte_hit = (sfr_addr_i == T2C_CTRL_ADDR) && (sfr_page_i == T2C_CTRL_PAGE);
    assign bit_hit = (sfr_addr_i[7:3] == T2C_BIT_BASE) && (sfr_page_i == T2C_CTRL_PAGE);
    assign bit_idx = sfr_addr_i[2:0];

    always_comb begin
        wr_mask = 8'h00;
        wr_val = 8'h00;
        if (sfr_wr_i && byte_hit) begin
            wr_mask = 8'hFF;
            wr_val = sfr_wdata_i;
        end else if (sfr_bit_wr_i && bit_hit) begin
            wr_mask[bit_idx] = 1'b1;
            wr_val = {8{sfr_bit_val_i}};
        end
        wr_mask[T2C_POS_UNUSED] = 1'b0;
    end

    // hardware sets win over a software clear in the same cycle
    always_comb begin
        ctrl_d = t2c_ctrl_type'((ctrl_q & ~wr_mask) | (wr_val & wr_mask));
        ctrl_d.unused = 1'b0;
        if (hi_set) begin
            ctrl_d.high_overflow_flag = 1'b1;
        end
        if (lo_set) begin
            ctrl_d.low_overflow_flag = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            ctrl_q <= t2c_ctrl_type'(T2C_CTRL_RESET);
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // registered read answer
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            rdata_q <= T2C_BYTE_RESET;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= sfr_rd_i && byte_hit;
            rdata_q <= (sfr_rd_i && byte_hit) ? ctrl_q : T2C_BYTE_RESET;
        end
    end

    // system clock divided by twelve
    always_ff @(posedge clk_sys_i) begin
        if (srst_i || div12_tick) begin
            div_q <= T2C_DIV12_RESET;
        end else begin
            div_q <= div_q + 4'h1;
        end
    end

    assign div12_tick = (div_q == T2C_DIV12_LAST);

    t2c_ext_sync u_ext_sync (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .ext_i(ext_clk_div8_i),
        .fall_o(ext_tick)
    );

    // clock source per byte
    assign lo_tick = low_byte_system_clock_select_i ? 1'b1
                   : (ctrl_q.external_clock_select ? ext_tick : div12_tick);
    assign hi_tick = high_byte_system_clock_select_i ? 1'b1
                   : (ctrl_q.external_clock_select ? ext_tick : div12_tick);

    // counting in split and 16-bit modes
    always_comb begin
        if (ctrl_q.split_mode_select) begin
            lo_inc = lo_tick;
            lo_load = lo_wrap;
            hi_inc = ctrl_q.run_control && hi_tick;
            hi_load = hi_wrap;
        end else begin
            lo_inc = ctrl_q.run_control && lo_tick;
            lo_load = full_wrap;
            hi_inc = lo_wrap;
            hi_load = full_wrap;
        end
    end

    assign full_wrap = !ctrl_q.split_mode_select && lo_wrap && hi_wrap;

    t2c_count_byte #(.W(8)) u_low_byte (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .inc_i(lo_inc),
        .load_i(lo_load),
        .load_val_i(reload_i.low),
        .count_o(count.low),
        .wrap_o(lo_wrap)
    );

    t2c_count_byte #(.W(8)) u_high_byte (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .inc_i(hi_inc),
        .load_i(hi_load),
        .load_val_i(reload_i.high),
        .count_o(count.high),
        .wrap_o(hi_wrap)
    );

    // flag set sources
    assign cap_evt = ext_tick && ctrl_q.capture_mode_enable;
    assign hi_set = hi_wrap || cap_evt;
    assign lo_set = lo_wrap;

    // capture copy for the reload registers
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            cap_valid_q <= 1'b0;
            cap_value_q <= '0;
        end else begin
            cap_valid_q <= cap_evt;
            if (cap_evt) begin
                cap_value_q <= count;
            end
        end
    end

    assign irq_o = timer_irq_enable_i && (ctrl_q.high_overflow_flag
                 || (ctrl_q.low_byte_irq_enable && ctrl_q.low_overflow_flag));
    assign sfr_rdata_o = rdata_q;
    assign sfr_rvalid_o = rvalid_q;
    assign count_o = count;
    assign capture_valid_o = cap_valid_q;
    assign capture_value_o = cap_value_q;

    // checks
    a_full_wrap_flag: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        full_wrap |=> ctrl_q.high_overflow_flag && count == $past(reload_i))
        else $error("16-bit wrap did not reload or set high flag");

    a_high_wrap_flag: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (hi_wrap && count.high == 8'hFF) |=> ctrl_q.high_overflow_flag)
        else $error("high byte wrap did not set high flag");

    a_flag_sticky: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (ctrl_q.high_overflow_flag && !wr_mask[T2C_POS_HI_FLAG])
        |=> ctrl_q.high_overflow_flag)
        else $error("high flag cleared without software");

    a_low_wrap_flag: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        lo_wrap |=> ctrl_q.low_overflow_flag
        && count.low == ($past(lo_load) ? $past(reload_i.low) : T2C_BYTE_RESET))
        else $error("low byte wrap did not set low flag");

    a_irq_high: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        $rose(ctrl_q.high_overflow_flag) && timer_irq_enable_i |-> irq_o)
        else $error("high flag did not raise interrupt");

    a_irq_low: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (ctrl_q.low_overflow_flag && ctrl_q.low_byte_irq_enable && timer_irq_enable_i)
        |-> irq_o)
        else $error("low flag did not raise interrupt");

    a_capture_copy: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        cap_evt |=> capture_valid_o && capture_value_o == $past(count)
        && ctrl_q.high_overflow_flag)
        else $error("capture did not copy count");

    a_split_hold: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (ctrl_q.split_mode_select && !ctrl_q.run_control) |=> $stable(count.high))
        else $error("high byte moved while stopped");

    a_unused_zero: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        sfr_rvalid_o |-> sfr_rdata_o[T2C_POS_UNUSED] == 1'b0)
        else $error("unused bit read as one");

    a_div12_gap: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        div12_tick |=> !div12_tick [*8] ##1 !div12_tick [*3] ##1 div12_tick)
        else $error("divide by twelve spacing wrong");

    c_full_wrap: cover property (@(posedge clk_sys_i) disable iff (srst_i) full_wrap);
    c_split_low: cover property (@(posedge clk_sys_i) disable iff (srst_i)
        ctrl_q.split_mode_select && lo_wrap);
    c_capture: cover property (@(posedge clk_sys_i) disable iff (srst_i) cap_evt);
    c_set_clear: cover property (@(posedge clk_sys_i) disable iff (srst_i)
        hi_set && wr_mask[T2C_POS_HI_FLAG] && !wr_val[T2C_POS_HI_FLAG]);

endmodule : t2c_timer_ctrl

// *** testbench/t2c_osc_model.sv ***
// model of the external oscillator divided by eight, idle high while stopped
module t2c_osc_model #(
    parameter int HALF_NS = 170,
    parameter int PHASE_NS = 5
) (
    input wire logic run_i,
    output logic clk_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        clk_o = 1'b1;
        // offset keeps pin edges away from system clock edges
        #PHASE_NS;
        forever begin
            #HALF_NS;
            clk_o = run_i ? ~clk_o : 1'b1;
        end
    end
endmodule : t2c_osc_model

// *** testbench/t2c_timer_ctrl_tb.sv ***
// self-checking bench of the timer two control block
module t2c_timer_ctrl_tb
    import t2c_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, srst, wr_s, rd_s, bwr, bval, ten, hsel, lsel, osc_run, ext, rvalid, irq, cvalid;
    logic [7:0] addr, page, wdata, rdata;
    t2c_count_type reload, count, cval, c0;
    int fail_count, n_compared, k;
    logic [15:0] rows [4] = '{16'h0200, 16'h3b39, 16'hc0c0, 16'h0000};

    t2c_timer_ctrl DUT (
        .clk_sys_i(clk),
        .srst_i(srst),
        .sfr_addr_i(addr),
        .sfr_page_i(page),
        .sfr_wr_i(wr_s),
        .sfr_rd_i(rd_s),
        .sfr_wdata_i(wdata),
        .sfr_bit_wr_i(bwr),
        .sfr_bit_val_i(bval),
        .timer_irq_enable_i(ten),
        .high_byte_system_clock_select_i(hsel),
        .low_byte_system_clock_select_i(lsel),
        .reload_i(reload),
        .ext_clk_div8_i(ext),
        .sfr_rdata_o(rdata),
        .sfr_rvalid_o(rvalid),
        .irq_o(irq),
        .count_o(count),
        .capture_valid_o(cvalid),
        .capture_value_o(cval)
    );
    t2c_osc_model #(.HALF_NS(170)) osc (.run_i(osc_run), .clk_o(ext));

    always #10 clk = ~clk;

    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr_s = 1'b1;
        @(negedge clk);
        wr_s = 1'b0;
    endtask : wr

    task automatic bw(input logic [7:0] a, input logic v);
        @(negedge clk);
        addr = a;
        bval = v;
        bwr = 1'b1;
        @(negedge clk);
        bwr = 1'b0;
    endtask : bw

    // read the control byte, checking valid and the masked data
    task automatic rdc(input logic v, input logic [7:0] d, input logic [7:0] m);
        @(negedge clk);
        addr = 8'hc8;
        rd_s = 1'b1;
        @(negedge clk);
        rd_s = 1'b0;
        chk("rvalid", 16'(rvalid), 16'(v));
        chk("ctrl", 16'(rdata & m), 16'(d));
    endtask : rdc

    task automatic waitcap();
        k = 0;
        while (cvalid !== 1'b1 && k < 100) begin
            cyc(1);
            k++;
        end
        if (k >= 100) fail_count++;
    endtask : waitcap

    task automatic done(input string nm);
        $display("test %s finished", nm);
    endtask : done

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run

    initial begin
        #1_800_000;
        fail_count++;
        complete_run();
    end

    initial begin
        {clk, wr_s, rd_s, bwr, bval, hsel, lsel, osc_run} = 8'h00;
        srst = 1'b1;
        ten = 1'b1;
        addr = 8'hc8;
        page = 8'h00;
        wdata = 8'h00;
        reload = 16'h0000;
        cyc(4);
        srst = 1'b0;
        rdc(1'b1, 8'h00, 8'hff);
        page = 8'h01;
        rdc(1'b0, 8'h00, 8'hff);
        page = 8'h00;
        foreach (rows[i]) begin
            wr(8'hc8, rows[i][15:8]);
            rdc(1'b1, rows[i][7:0], 8'hff);
        end
        done("rows");
        bw(8'hca, 1'b1);
        bw(8'hc9, 1'b1);
        rdc(1'b1, 8'h04, 8'hff);
        wr(8'hc8, 8'h3b);
        srst = 1'b1;
        cyc(1);
        srst = 1'b0;
        rdc(1'b1, 8'h00, 8'hff);
        done("reset");
        lsel = 1'b1;
        reload = 16'hfff0;
        wr(8'hc8, 8'h04);
        k = 0;
        while (count !== 16'hffff && k < 70000) begin
            cyc(1);
            k++;
        end
        if (k >= 70000) fail_count++;
        cyc(1);
        chk("reload", count, 16'hfff0);
        rdc(1'b1, 8'hc4, 8'hff);
        chk("irq", 16'(irq), 16'h0001);
        bw(8'hca, 1'b0);
        cyc(30);
        rdc(1'b1, 8'hc0, 8'hff);
        bw(8'hcf, 1'b0);
        chk("irq low off", 16'(irq), 16'h0000);
        bw(8'hcd, 1'b1);
        chk("irq low on", 16'(irq), 16'h0001);
        ten = 1'b0;
        cyc(1);
        chk("irq off", 16'(irq), 16'h0000);
        ten = 1'b1;
        done("sixteen");
        hsel = 1'b1;
        reload = 16'h10f0;
        wr(8'hc8, 8'h08);
        c0 = count;
        k = 0;
        while (count.low !== 8'hff && k < 300) begin
            cyc(1);
            k++;
        end
        if (k >= 300) fail_count++;
        cyc(1);
        chk("low reload", 16'(count.low), 16'h00f0);
        chk("high held", 16'(count.high), 16'(c0.high));
        wr(8'hc8, 8'h0c);
        k = 0;
        while (count.high !== 8'h10 && k < 20) begin
            cyc(1);
            k++;
        end
        if (k >= 20) fail_count++;
        chk("high reload", 16'(count.high), 16'h0010);
        rdc(1'b1, 8'h80, 8'h80);
        done("split");
        hsel = 1'b0;
        lsel = 1'b0;
        reload = 16'h0000;
        wr(8'hc8, 8'h04);
        c0 = count;
        cyc(24);
        chk("div12", count - c0, 16'h0002);
        osc_run = 1'b1;
        wr(8'hc8, 8'h05);
        cyc(30);
        c0 = count;
        cyc(170);
        chk("ext", count - c0, 16'h000a);
        done("clocks");
        lsel = 1'b1;
        wr(8'hc8, 8'h14);
        waitcap();
        c0 = cval;
        cyc(1);
        waitcap();
        chk("period", cval - c0, 16'h0011);
        rdc(1'b1, 8'h80, 8'h80);
        wr(8'hc8, 8'h04);
        cyc(2);
        k = 0;
        repeat (40) begin
            cyc(1);
            if (cvalid === 1'b1) k++;
        end
        chk("no capture", 16'(k), 16'h0000);
        done("capture");
        complete_run();
    end
endmodule : t2c_timer_ctrl_tb
